// File: verilog/tx_control.sv
// transmit control of a rolling-code remote encoder: buttons in, code word out
// assumes buttons come from pins (synchronised here) and one 200 MHz clock
`timescale 1ns/10ps
module tx_control #(
  parameter int TICK_CYCLES = tx_control_pkg::TICK_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic [3:0]  i_button,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  output logic             o_data,
  output logic             o_busy
);
  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_GUARD, ST_OFF} state_t;

  state_t      state;
  logic [3:0]  btn_meta;
  logic [3:0]  btn;
  logic [12:0] config_reg;
  logic [31:0] serial;
  logic [31:0] seed_lo;
  logic [15:0] seed_hi;
  logic [15:0] counter_a;
  logic [7:0]  disc;
  logic        overflow;
  logic [3:0]  btn_code;
  logic        delayed_on;
  logic        shut_down;
  logic [63:0] word;
  logic [5:0]  bit_idx;
  logic        ser_start;
  logic        ser_done;
  logic        ser_level;
  logic [tx_control_pkg::TE_W-1:0] te_cycles;
  logic [17:0] guard_cnt;
  logic [7:0]  guard_te;
  logic [31:0] tick_cnt;
  logic        ms_tick;
  logic [15:0] held_ms;
  logic [15:0] shutoff_ms;
  logic [15:0] delay_ms;
  logic [11:0] ir_cnt;
  logic        carrier;
  logic        use_b;
  logic        activate;
  logic        cfg_lock;
  logic        guard_end;
  logic [15:0] active_cnt;
  logic [15:0] next_cnt;
  logic        next_overflow;
  logic        seed_ok;
  logic [63:0] next_word;
  logic        infrared_modulation;

  localparam int TE_W_L = tx_control_pkg::TE_W;
  localparam logic [TE_W_L-1:0] TE_CYC_0 = TE_W_L'(tx_control_pkg::TE_US_0 * tx_control_pkg::CLK_MHZ);
  localparam logic [TE_W_L-1:0] TE_CYC_1 = TE_W_L'(tx_control_pkg::TE_US_1 * tx_control_pkg::CLK_MHZ);
  localparam logic [TE_W_L-1:0] TE_CYC_2 = TE_W_L'(tx_control_pkg::TE_US_2 * tx_control_pkg::CLK_MHZ);
  localparam logic [TE_W_L-1:0] TE_CYC_3 = TE_W_L'(tx_control_pkg::TE_US_3 * tx_control_pkg::CLK_MHZ);
  localparam logic [11:0] IR_HALF = 12'(tx_control_pkg::IR_HALF_CYC);
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  // buttons are raw pins
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      btn_meta <= 4'h0;
      btn      <= 4'h0;
    end else begin
      btn_meta <= i_button;
      btn      <= btn_meta;
    end
  end

  // element time and scaled timeouts from the baud selection
  always_comb begin
    case (config_reg[tx_control_pkg::CFG_BAUD_LO +: 2])
      2'd0:    te_cycles = TE_CYC_0;
      2'd1:    te_cycles = TE_CYC_1;
      2'd2:    te_cycles = TE_CYC_2;
      default: te_cycles = TE_CYC_3;
    endcase
  end

  // faster baud settings shorten both the delay and the shut-off time
  assign shutoff_ms = 16'(tx_control_pkg::SHUTOFF_MS) >> (2'd3 - config_reg[tx_control_pkg::CFG_BAUD_LO +: 2]);
  assign delay_ms   = 16'(tx_control_pkg::DELAY_MS) >> (2'd3 - config_reg[tx_control_pkg::CFG_BAUD_LO +: 2]);
  assign guard_te   = config_reg[tx_control_pkg::CFG_LONG_GUARD] ?
                      8'(tx_control_pkg::LONG_GUARD_TE) : 8'(tx_control_pkg::GUARD_TE);

  assign activate = (state == ST_IDLE) && (btn != 4'h0);
  assign cfg_lock = (state != ST_IDLE) || activate;
  assign use_b    = config_reg[tx_control_pkg::CFG_INDEPENDENT] && btn[2];

  // counter step, with the overflow extension of the 64k range
  always_comb begin
    active_cnt    = use_b ? seed_hi : counter_a;
    next_cnt      = active_cnt + 16'h0001;
    next_overflow = overflow;
    if (active_cnt == 16'hffff) begin
      next_overflow = 1'b0;
    end
  end

  assign seed_ok = !(config_reg[tx_control_pkg::CFG_TEMP_SEED] && (counter_a >= tx_control_pkg::TEMP_SEED_END));

  function automatic logic [63:0] build_word(input logic [15:0] cnt, input logic ovf, input logic [3:0] code,
                                             input logic delayed);
    logic [9:0]  dfield;
    logic [31:0] fixed;
    logic [63:0] w;
    dfield[7:0] = disc;
    dfield[9:8] = config_reg[tx_control_pkg::CFG_USER_CUSTOM] ?
                  config_reg[tx_control_pkg::CFG_USER_LO +: 2] :
                  serial[tx_control_pkg::SERIAL_USER_LO +: 2];
    if (delayed) begin
      dfield[3:0] = ~dfield[3:0];
    end
    fixed = config_reg[tx_control_pkg::CFG_SERIAL_32] ? serial : {code, serial[27:0]};
    w     = {fixed, code, 1'b0, ovf, dfield, cnt};
    if (code == tx_control_pkg::SEED_FUNC && seed_ok) begin
      // in independent mode the upper seed half is counter B, sent as is
      w[47:0] = {seed_hi, seed_lo};
    end
    return w;
  endfunction

  always_comb begin
    if (activate) begin
      next_word = build_word(next_cnt, next_overflow, btn, 1'b0);
    end else begin
      next_word = build_word(use_b ? seed_hi : counter_a, overflow, btn_code, delayed_on);
    end
  end

  // software access; settings are frozen once a transmission starts
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      config_reg <= tx_control_pkg::CONFIG_RESET;
      serial     <= 32'h0000_0000;
      seed_lo    <= 32'h0000_0000;
      disc       <= 8'h00;
    end else if (i_wr && !cfg_lock) begin
      case (i_addr)
        tx_control_pkg::ADDR_CONFIG:  config_reg <= i_wdata[tx_control_pkg::CFG_WIDTH-1:0];
        tx_control_pkg::ADDR_SERIAL:  serial     <= i_wdata;
        tx_control_pkg::ADDR_SEED_LO: seed_lo    <= i_wdata;
        tx_control_pkg::ADDR_DISC:    disc       <= i_wdata[7:0];
        default: ;
      endcase
    end
  end

  // both counters: preset by software; the one picked by use_b is advanced on activation
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      counter_a <= 16'h0000;
      seed_hi   <= 16'h0000;
      overflow  <= 1'b0;
    end else if (activate) begin
      overflow <= next_overflow;
      if (use_b) begin
        seed_hi <= next_cnt;
      end else begin
        counter_a <= next_cnt;
      end
    end else if (i_wr && !cfg_lock) begin
      if (i_addr == tx_control_pkg::ADDR_COUNTER_A) begin
        counter_a <= i_wdata[15:0];
      end
      if (i_addr == tx_control_pkg::ADDR_SEED_HI) begin
        seed_hi <= i_wdata[15:0];
      end
      if (i_addr == tx_control_pkg::ADDR_CONFIG) begin
        overflow <= i_wdata[tx_control_pkg::CFG_OVERFLOW];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        tx_control_pkg::ADDR_CONFIG:    o_rdata <= {19'h0_0000, config_reg};
        tx_control_pkg::ADDR_SERIAL:    o_rdata <= serial;
        tx_control_pkg::ADDR_SEED_LO:   o_rdata <= seed_lo;
        tx_control_pkg::ADDR_SEED_HI:   o_rdata <= {16'h0000, seed_hi};
        tx_control_pkg::ADDR_COUNTER_A: o_rdata <= {16'h0000, counter_a};
        tx_control_pkg::ADDR_DISC:      o_rdata <= {24'h00_0000, disc};
        tx_control_pkg::ADDR_STATUS:    o_rdata <= {24'h00_0000, btn, shut_down, delayed_on, overflow,
                                                    (state != ST_IDLE)};
        default:                        o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // millisecond time base for the hold timers
  assign ms_tick = (tick_cnt == TICK_LAST);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_cnt <= 32'h0000_0000;
      held_ms  <= 16'h0000;
    end else if (state == ST_IDLE) begin
      tick_cnt <= 32'h0000_0000;
      held_ms  <= 16'h0000;
    end else begin
      tick_cnt <= ms_tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
      if (ms_tick && held_ms != 16'hffff) begin
        held_ms <= held_ms + 16'h0001;
      end
    end
  end

  assign guard_end = (state == ST_GUARD) && (guard_cnt == {guard_te, 10'h000} - 18'h0_0001);

  // word sequencer
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state      <= ST_IDLE;
      word       <= 64'h0000_0000_0000_0000;
      bit_idx    <= 6'd0;
      ser_start  <= 1'b0;
      btn_code   <= 4'h0;
      delayed_on <= 1'b0;
      shut_down  <= 1'b0;
      guard_cnt  <= 18'h0_0000;
    end else begin
      ser_start <= 1'b0;
      case (state)
        ST_IDLE: begin
          delayed_on <= 1'b0;
          if (activate) begin
            shut_down <= 1'b0;
            btn_code  <= btn;
            word      <= next_word;
            bit_idx   <= 6'd0;
            ser_start <= 1'b1;
            state     <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (ser_done) begin
            if (bit_idx == 6'(tx_control_pkg::WORD_BITS - 1)) begin
              guard_cnt <= 18'h0_0000;
              state     <= ST_GUARD;
            end else begin
              bit_idx   <= bit_idx + 6'd1;
              ser_start <= 1'b1;
            end
          end
        end
        ST_GUARD: begin
          // guard counts clock cycles, 1024 per guard_te unit, whatever the element time
          guard_cnt <= guard_cnt + 18'h0_0001;
          if (guard_end) begin
            if (btn == 4'h0) begin
              state <= ST_IDLE;
            end else if (config_reg[tx_control_pkg::CFG_AUTO_OFF] && held_ms >= shutoff_ms) begin
              shut_down <= 1'b1;
              state     <= ST_OFF;
            end else begin
              if (config_reg[tx_control_pkg::CFG_DELAYED] && held_ms >= delay_ms) begin
                delayed_on <= 1'b1;
                word       <= build_word(use_b ? seed_hi : counter_a, overflow, btn_code, 1'b1);
              end else begin
                word <= next_word;
              end
              bit_idx   <= 6'd0;
              ser_start <= 1'b1;
              state     <= ST_SEND;
            end
          end
        end
        ST_OFF: begin
          if (btn == 4'h0) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  element_serializer #(
    .TE_W(TE_W_L)
  ) u_serializer (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_start     (ser_start),
    .i_bit       (word[bit_idx]),
    .i_manchester(config_reg[tx_control_pkg::CFG_MANCHESTER]),
    .i_te_cycles (te_cycles),
    .o_level     (ser_level),
    .o_done      (ser_done)
  );

  // infrared carrier
  assign infrared_modulation = config_reg[tx_control_pkg::CFG_INDEPENDENT] && btn_code[1] && btn_code[2];

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ir_cnt  <= 12'h000;
      carrier <= 1'b0;
    end else if (ir_cnt == IR_HALF - 12'h001) begin
      ir_cnt  <= 12'h000;
      carrier <= ~carrier;
    end else begin
      ir_cnt <= ir_cnt + 12'h001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_data <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_data <= (state == ST_SEND) && ser_level && (!infrared_modulation || carrier);
      o_busy <= (state != ST_IDLE) || activate;
    end
  end
endmodule

// File: inc/tx_control_pkg.sv
// constants for the rolling-code encoder transmit control block
// assumes a 200 MHz system clock and a plain strobe register port
//
// Notes on behaviour
// - output modulation is PWM or Manchester, chosen by a config bit.
// - serial number is sent as 28 bits or full 32 bits.
// - temporary seed option stops seed words once counter reaches 0x80.
// - seed function sends 48-bit seed over hopping part and low serial bits.
// - independent mode keeps counter B in upper 16 seed bits.
// - independent mode uses and advances counter B when button three active.
// - independent mode with buttons two and three modulates output at 40 kHz.
// - auto shut-off stops sending after continuous time set by baud rate.
// - overflow set: first wrap FFFF to 0000 clears overflow bit.
// - later wraps leave overflow clear, repeating last 64k sequence.
// - delayed mode sends modified word once button held beyond baud-set time.
// - modified word inverts lowest nibble of discrimination field.
// - baud select sets element time and scales delay and shut-off time.
// - long guard option lengthens guard spacing between words.
// - both counters are 16 bits, preset by software to any value.
// - two user bits extend discrimination, default serial bits 8 and 9.
package tx_control_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CONFIG    = 8'h00;
  localparam logic [7:0] ADDR_SERIAL    = 8'h04;
  localparam logic [7:0] ADDR_SEED_LO   = 8'h08;
  localparam logic [7:0] ADDR_SEED_HI   = 8'h0c;
  localparam logic [7:0] ADDR_COUNTER_A = 8'h10;
  localparam logic [7:0] ADDR_DISC      = 8'h14;
  localparam logic [7:0] ADDR_STATUS    = 8'h18;
  // config field positions
  localparam int CFG_MANCHESTER  = 0;
  localparam int CFG_SERIAL_32   = 1;
  localparam int CFG_TEMP_SEED   = 2;
  localparam int CFG_INDEPENDENT = 3;
  localparam int CFG_AUTO_OFF    = 4;
  localparam int CFG_OVERFLOW    = 5;
  localparam int CFG_LONG_GUARD  = 6;
  localparam int CFG_DELAYED     = 7;
  localparam int CFG_BAUD_LO     = 8;
  localparam int CFG_USER_LO     = 10;
  localparam int CFG_USER_CUSTOM = 12;
  localparam int CFG_WIDTH       = 13;
  localparam logic [12:0] CONFIG_RESET = 13'h0000;
  // code word
  localparam int WORD_BITS = 64;
  localparam logic [3:0] SEED_FUNC      = 4'h9;
  localparam logic [15:0] TEMP_SEED_END = 16'h0080;
  localparam int SERIAL_USER_LO = 8;
  // timing
  localparam int CLK_MHZ        = 200;
  localparam int TE_US_0        = 100;
  localparam int TE_US_1        = 200;
  localparam int TE_US_2        = 400;
  localparam int TE_US_3        = 800;
  localparam int GUARD_TE       = 16;
  localparam int LONG_GUARD_TE  = 50;
  localparam int IR_FREQ_KHZ    = 40;
  localparam int IR_HALF_CYC    = (CLK_MHZ * 1000) / (2 * IR_FREQ_KHZ);
  localparam int TICK_MS        = 1;
  localparam int TICK_CYC       = TICK_MS * CLK_MHZ * 1000;
  localparam int SHUTOFF_MS     = 25600;
  localparam int DELAY_MS       = 1600;
  localparam int TE_W           = 18;
endpackage

// File: verilog/element_serializer.sv
// sends one data bit as PWM (three elements) or Manchester (two elements)
// assumes i_start only arrives while idle or in the cycle of o_done
`timescale 1ns/10ps
module element_serializer #(
  parameter int TE_W = 18
) (
  input  wire logic            i_clk,
  input  wire logic            i_rst_b,
  input  wire logic            i_start,
  input  wire logic            i_bit,
  input  wire logic            i_manchester,
  input  wire logic [TE_W-1:0] i_te_cycles,
  output logic                 o_level,
  output logic                 o_done
);
  logic            busy;
  logic            bit_val;
  logic            manch;
  logic [1:0]      phase;
  logic [TE_W-1:0] te_cnt;
  logic            te_end;
  logic            last_phase;

  assign te_end     = busy && (te_cnt == i_te_cycles - 1'b1);
  assign last_phase = manch ? (phase == 2'd1) : (phase == 2'd2);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy    <= 1'b0;
      bit_val <= 1'b0;
      manch   <= 1'b0;
      phase   <= 2'd0;
      te_cnt  <= '0;
    end else if (i_start) begin
      busy    <= 1'b1;
      bit_val <= i_bit;
      manch   <= i_manchester;
      phase   <= 2'd0;
      te_cnt  <= '0;
    end else if (te_end) begin
      te_cnt <= '0;
      phase  <= phase + 2'd1;
      if (last_phase) begin
        busy <= 1'b0;
      end
    end else if (busy) begin
      te_cnt <= te_cnt + 1'b1;
    end
  end

  // level is registered so the pin never glitches between phases
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_level <= 1'b0;
    end else if (i_start) begin
      o_level <= i_manchester ? i_bit : 1'b1;
    end else if (te_end && !last_phase) begin
      if (manch) begin
        o_level <= ~bit_val;
      end else begin
        o_level <= (phase == 2'd0) ? ~bit_val : 1'b0;
      end
    end else if (te_end) begin
      o_level <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_done <= 1'b0;
    end else begin
      o_done <= te_end && last_phase;
    end
  end
endmodule

// File: sim/tx_control_properties.sv
// port-level checker for tx_control: read answers, activation and element timing
// assumes config is written only while the block is idle, as the bench does
`timescale 1ns/10ps
module tx_control_properties #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic [3:0]  i_button,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        o_data,
  input wire logic        o_busy
);
  logic [12:0] cfg;
  logic [19:0] hi_run;
  logic [19:0] te;
  logic        ir;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // shadow of config; the block drops writes while busy
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg <= tx_control_pkg::CONFIG_RESET;
    end else if (i_wr && !o_busy && i_addr == tx_control_pkg::ADDR_CONFIG) begin
      cfg <= i_wdata[12:0];
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hi_run <= 20'h0_0000;
    end else begin
      hi_run <= o_data ? hi_run + 20'h0_0001 : 20'h0_0000;
    end
  end
  // element time doubles with each baud step
  assign te = 20'(tx_control_pkg::TE_US_0 * tx_control_pkg::CLK_MHZ) << cfg[9:8];
  assign ir = cfg[tx_control_pkg::CFG_INDEPENDENT] && i_button[2:1] == 2'h3;

  AST_RDATA_QUIET: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside the answer cycle");
  AST_UNMAPPED_ZERO: assert property (i_rd && i_addr >= 8'h1c |=> o_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_CONFIG_READBACK: assert property (i_rd && i_addr == tx_control_pkg::ADDR_CONFIG
    |=> o_rdata == {19'h0_0000, $past(cfg)}) else $error("config read back wrong");
  AST_ACTIVATE: assert property (!o_busy && $past(i_button) == 4'h0 && i_button != 4'h0
    |-> ##[1:6] o_busy) else $error("press did not start a transmission");
  AST_BUSY_HOLDS: assert property ($rose(o_busy) |-> o_busy [*8])
    else $error("busy dropped right after activation");
  AST_IDLE_QUIET: assert property (!o_busy |-> !o_data)
    else $error("line active while idle");
  AST_PWM_LEADS_HIGH: assert property ($rose(o_busy) && !cfg[tx_control_pkg::CFG_MANCHESTER] && !ir
    |-> ##[0:3] o_data) else $error("pwm word did not open with a mark");
  AST_ELEMENT_WIDTH: assert property ($fell(o_data) && !ir |-> (hi_run >= te - 1 && hi_run <= te + 2)
    || (hi_run >= 2 * te - 1 && hi_run <= 2 * te + 2)) else $error("mark not one or two element times");
  AST_IR_CHOPPED: assert property ($fell(o_data) && ir && o_busy
    |-> hi_run <= tx_control_pkg::IR_HALF_CYC + 1) else $error("infrared mark longer than half a carrier");
endmodule
bind tx_control tx_control_properties #(.TICK_CYCLES(TICK_CYCLES)) tx_control_properties_inst (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_button(i_button), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_data(o_data), .o_busy(o_busy));

// File: sim/link_receiver.sv
// far-side receiver model: times the first mark and the space after it
// assumes the line idles low and is reset together with the encoder
`timescale 1ns/10ps
module link_receiver (
  input  wire logic   i_clk,
  input  wire logic   i_rst_b,
  input  wire logic   i_line,
  output logic [19:0] o_high_len,
  output logic [19:0] o_low_len,
  output logic        o_high_done,
  output logic        o_low_done
);
  logic prev;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev <= 1'b0;
      o_high_len <= 20'h0_0000;
      o_low_len <= 20'h0_0000;
      o_high_done <= 1'b0;
      o_low_done <= 1'b0;
    end else begin
      prev <= i_line;
      // mark length tells a one from a zero in pwm
      if (i_line && !o_high_done) begin
        o_high_len <= o_high_len + 20'h0_0001;
      end
      if (prev && !i_line) begin
        o_high_done <= 1'b1;
      end
      if ((o_high_done || prev) && !i_line && !o_low_done) begin
        o_low_len <= o_low_len + 20'h0_0001;
      end
      if (o_high_done && i_line) begin
        o_low_done <= 1'b1;
      end
    end
  end
endmodule

// File: sim/test_tx_control.sv
// self-checking bench for tx_control: registers, counters and first element timing
// assumes a short hold tick; full words are too long to run, so only leading elements are timed
`timescale 1ns/10ps
module test_tx_control;
  logic        i_clk;
  logic        i_rst_b;
  logic [3:0]  i_button;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        o_data;
  logic        o_busy;
  logic [19:0] high_len;
  logic [19:0] low_len;
  logic        high_done;
  logic        low_done;
  int          fails;
  int          tests_run;
  int          cycles;
  localparam int TE0 = tx_control_pkg::TE_US_0 * tx_control_pkg::CLK_MHZ;
  logic [7:0]  addrs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  logic [31:0] masks [6] = '{32'h0000_1fff, 32'hffff_ffff, 32'hffff_ffff, 32'h0000_ffff, 32'h0000_ffff,
                             32'h0000_00ff};

  tx_control #(.TICK_CYCLES(10)) tx_control_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_button(i_button),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_data(o_data),
    .o_busy(o_busy));
  link_receiver link_receiver_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_line(o_data),
    .o_high_len(high_len), .o_low_len(low_len), .o_high_done(high_done), .o_low_done(low_done));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fails++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks run %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp32(input string name, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cmp_len(input string name, input int lo, input int hi, input logic [19:0] seen);
    tests_run++;
    if ($isunknown(seen) || seen < lo || seen > hi) begin
      fails++;
      $display("FAIL %s expected %0d to %0d seen %0d", name, lo, hi, seen);
    end
  endtask
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= addr;
    i_wdata <= data;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input string name);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= addr;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    cmp32(name, exp, o_rdata);
  endtask
  // buttons drop with reset so no half-chopped mark is judged after release
  task automatic restart();
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    i_button <= 4'h0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
  endtask
  task automatic press(input logic [3:0] b);
    int n;
    n = 0;
    @(posedge i_clk);
    i_button <= b;
    while (o_busy !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    cmp32("busy", 32'h0000_0001, {31'h0000_0000, o_busy});
  endtask
  task automatic wait_flag(input logic want_space);
    int n;
    n = 0;
    while ((want_space ? low_done : high_done) !== 1'b1 && n < 50000) begin
      @(negedge i_clk);
      n++;
    end
  endtask

  initial begin
    i_rst_b = 1'b0;
    i_button = 4'h0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd(tx_control_pkg::ADDR_CONFIG, 32'h0000_0000, "config reset");
    rd(tx_control_pkg::ADDR_COUNTER_A, 32'h0000_0000, "counter reset");
    rd(tx_control_pkg::ADDR_STATUS, 32'h0000_0000, "status reset");
    for (int i = 0; i < 6; i++) begin
      wr(addrs[i], 32'hffff_ffff);
      rd(addrs[i], masks[i], "register width");
    end
    wr(tx_control_pkg::ADDR_STATUS, 32'h0000_0000);
    rd(tx_control_pkg::ADDR_STATUS, 32'h0000_0002, "status read only");
    wr(8'h1c, 32'hffff_ffff);
    rd(8'h1c, 32'h0000_0000, "unmapped");
    // wrap with and without the overflow extension; a write while busy must be dropped
    for (int k = 0; k < 2; k++) begin
      restart();
      wr(tx_control_pkg::ADDR_CONFIG, k == 0 ? 32'h0000_0020 : 32'h0000_0000);
      wr(tx_control_pkg::ADDR_COUNTER_A, 32'h0000_ffff);
      press(4'h1);
      wr(tx_control_pkg::ADDR_COUNTER_A, 32'h0000_1234);
      rd(tx_control_pkg::ADDR_COUNTER_A, 32'h0000_0000, "counter wrap");
      rd(tx_control_pkg::ADDR_STATUS, 32'h0000_0011, "status after wrap");
    end
    // pwm then manchester: first bit is one only if the counter advanced first
    for (int k = 0; k < 2; k++) begin
      restart();
      wr(tx_control_pkg::ADDR_CONFIG, {31'h0000_0000, k[0]});
      wr(tx_control_pkg::ADDR_COUNTER_A, k == 0 ? 32'h0000_0004 : 32'h0000_0002);
      press(4'h1);
      wait_flag(k[0]);
      cmp_len("first mark", TE0 - 1, TE0 + 1, high_len);
      if (k == 1) begin
        // a manchester bit ends low, and the next bit starts two cycles after the done pulse
        cmp_len("first space", TE0 + 1, TE0 + 3, low_len);
      end
    end
    restart();
    wr(tx_control_pkg::ADDR_CONFIG, 32'h0000_0008);
    wr(tx_control_pkg::ADDR_SEED_HI, 32'h0000_0010);
    press(4'h6);
    rd(tx_control_pkg::ADDR_SEED_HI, 32'h0000_0011, "second counter");
    rd(tx_control_pkg::ADDR_COUNTER_A, 32'h0000_0000, "first counter held");
    wait_flag(1'b0);
    cmp_len("infrared mark", 1, tx_control_pkg::IR_HALF_CYC + 1, high_len);
    restart();
    close_out();
  end
endmodule
